//--- hw/ifss_ctrl.sv
// Filter depth, timed power-down, status flags and command register
`include "ifss_map.svh"

// Function
// - Taps equal two to the depth exponent
// - Tilt twice averaged, others averaged once
// - Tilt filter delay is twice the other
// - Depth selectable as powers of two, 1..256
// - Depth in low four bits, max eight
// - Sleep lasts count times half a second
// - Sleep count zero at reset and wake
// - Finish sample and update before sleeping
// - Wake only on expiry, reset or power
// - Output data held through power-down
// - Wait converter recovery time after waking
// - Clear new-data bits and pin before sleep
// - Power down auxiliary DAC while asleep
// - Other settings unchanged across power-down
// - Bit 14 of outputs flags any set status bit
// - Status bits report alarms and errors
// - Supply over and under flags, bits 1/0
// - Supply flags clear when back in range
// - Command bit 4 clears all flags
// - Flags re-set while condition persists
// - Commands written as ones, write-only, volatile
// - Command bits act once per write
module ifss_ctrl
#(
   parameter int unsigned SLEEP_UNIT_CYC = `IFSS_SLEEP_UNIT_CYC,
   parameter int unsigned RECOVER_CYC    = `IFSS_RECOVER_CYC,
   parameter int          DW             = 14
)
(
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  wire logic          reg_wr_en,
   input  wire logic          reg_rd_en,
   input  wire logic [6:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic [7:0]         reg_rdata,
   input  wire logic          sample_valid,
   input  wire logic [DW-1:0] raw_tilt_full,
   input  wire logic [DW-1:0] raw_tilt_half,
   input  wire logic [DW-1:0] raw_supply,
   input  wire logic [DW-1:0] raw_aux_adc,
   input  wire logic [DW-1:0] raw_temp,
   input  wire logic          cond_alarm2,
   input  wire logic          cond_alarm1,
   input  wire logic          cond_orient,
   input  wire logic          cond_selftest_fail,
   input  wire logic          cond_spi_fail,
   input  wire logic          cond_ctrl_fail,
   input  wire logic          supply_over,
   input  wire logic          supply_under,
   output logic [15:0]        tilt_full_circle_output,
   output logic [15:0]        tilt_signed_half_output,
   output logic [15:0]        supply_output,
   output logic [15:0]        aux_adc_output,
   output logic [15:0]        temp_output,
   output logic               new_data_pin,
   output logic               dac_power_down,
   output logic               cmd_soft_reset,
   output logic               cmd_flash_store,
   output logic               cmd_dac_latch,
   output logic               cmd_factory_reset,
   output logic               cmd_incl_null
);

   ifss_pkg::ifss_top_state_t r;
   ifss_pkg::ifss_top_state_t n;

   logic [4:0][DW-1:0] raw;
   logic [4:0][DW-1:0] s1_data;
   logic [4:0]         s1_vld;
   logic [1:0][DW-1:0] s2_data;
   logic [1:0]         s2_vld;
   logic [9:0]         cond_vec;
   logic               smp_ok;
   logic               upd;
   logic               filt_clear;
   logic               start_tick;
   logic               start_rec;
   logic               tick_done;
   logic               rec_done;

   ////////////////////////////////////////////////////////////////////////////
   // Filters

   assign raw    = {raw_temp, raw_aux_adc, raw_supply, raw_tilt_half, raw_tilt_full};
   assign smp_ok = sample_valid && (r.st == ifss_pkg::ifss_st_run);
   assign upd    = s2_vld[0];

   // One averaging stage per channel, window set by the depth exponent
   for (genvar g = 0; g < 5; g++)
   begin : g_s1
      ifss_mavg #(.W(DW), .LMAX(8)) u_avg
      (
         .mclk      (mclk),
         .rst_b     (rst_b),
         .clear     (filt_clear),
         .in_valid  (smp_ok),
         .depth_exp (r.fdepth),
         .in_data   (raw[g]),
         .out_valid (s1_vld[g]),
         .out_data  (s1_data[g])
      );
   end

   // Second stage on both tilt channels makes a triangular window
   for (genvar g = 0; g < 2; g++)
   begin : g_s2
      ifss_mavg #(.W(DW), .LMAX(8)) u_avg
      (
         .mclk      (mclk),
         .rst_b     (rst_b),
         .clear     (filt_clear),
         .in_valid  (s1_vld[g]),
         .depth_exp (r.fdepth),
         .in_data   (s1_data[g]),
         .out_valid (s2_vld[g]),
         .out_data  (s2_data[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timers for sleep units and converter recovery

   ifss_down_timer #(.CW(32)) u_tick
   (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .start  (start_tick),
      .length (32'(SLEEP_UNIT_CYC)),
      .done   (tick_done)
   );

   ifss_down_timer #(.CW(32)) u_recover
   (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .start  (start_rec),
      .length (32'(RECOVER_CYC)),
      .done   (rec_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   // Raw condition levels at their status positions
   assign cond_vec = {cond_alarm2, cond_alarm1, 1'b0, cond_orient, cond_selftest_fail, 1'b0,
                      cond_spi_fail, cond_ctrl_fail, supply_over, supply_under};

   always_comb
   begin
      n          = r;
      n.cmd      = 8'h00;
      n.rdata    = 8'h00;
      start_tick = 1'b0;
      start_rec  = 1'b0;

      // Sticky flags: set wins over clear; supply flags follow the level
      n.stat = cond_vec |
               (r.stat & `IFSS_STAT_STICKY & {10{~r.cmd[`IFSS_CMD_CLEAR]}});

      // Register reads, unused bytes and bits as zero
      if (reg_rd_en)
      begin
         case (reg_addr)
            `IFSS_ADDR_FDEPTH_LO: n.rdata = {4'h0, r.fdepth};
            `IFSS_ADDR_SLEEP_LO:  n.rdata = r.slp;
            `IFSS_ADDR_STAT_LO:   n.rdata = r.stat[7:0];
            `IFSS_ADDR_STAT_HI:   n.rdata = {6'h00, r.stat[9:8]};
            default:              n.rdata = 8'h00;
         endcase
      end

      // Register writes
      if (reg_wr_en)
      begin
         case (reg_addr)
            `IFSS_ADDR_FDEPTH_LO:
            begin
               if (reg_wdata[3:0] <= `IFSS_FDEPTH_MAX)
                  n.fdepth = reg_wdata[3:0];
            end
            `IFSS_ADDR_SLEEP_LO:
            begin
               if (r.st == ifss_pkg::ifss_st_run)
                  n.slp = reg_wdata;
            end
            `IFSS_ADDR_CMD_LO:
               n.cmd = reg_wdata & `IFSS_CMD_MASK;
            default:
               n.cmd = 8'h00;
         endcase
      end

      // Power state machine; settings other than the sleep count untouched
      case (r.st)
         ifss_pkg::ifss_st_run:
         begin
            if (smp_ok)
               n.nd_pin = 1'b0;
            if (upd)
            begin
               for (int i = 0; i < 5; i++)
               begin
                  n.outs[i][`IFSS_OUT_ND]    = (r.slp == 8'h00);
                  n.outs[i][`IFSS_OUT_ALARM] = |r.stat;
                  n.outs[i][DW-1:0]          = (i < 2) ? s2_data[i[0]] : s1_data[i];
               end
               n.nd_pin = (r.slp == 8'h00);
               if (r.slp != 8'h00)
               begin
                  n.st       = ifss_pkg::ifss_st_sleep;
                  n.halves   = r.slp;
                  n.dac_pd   = 1'b1;
                  start_tick = 1'b1;
               end
            end
         end
         ifss_pkg::ifss_st_sleep:
         begin
            if (tick_done)
            begin
               if (r.halves == 8'h01)
               begin
                  n.st      = ifss_pkg::ifss_st_recover;
                  n.slp     = 8'h00;
                  n.dac_pd  = 1'b0;
                  start_rec = 1'b1;
               end
               else
               begin
                  n.halves   = r.halves - 8'h01;
                  start_tick = 1'b1;
               end
            end
         end
         ifss_pkg::ifss_st_recover:
         begin
            if (rec_done)
               n.st = ifss_pkg::ifss_st_run;
         end
         default:
            n.st = ifss_pkg::ifss_st_run;
      endcase
   end

   // Depth change or a reset command restarts every window
   assign filt_clear = (n.fdepth != r.fdepth) || r.cmd[`IFSS_CMD_FACTORY] || r.cmd[`IFSS_CMD_SOFT_RST];

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         r        <= '0;
         r.st     <= ifss_pkg::ifss_st_run;
         r.fdepth <= `IFSS_FDEPTH_RST;
         r.slp    <= `IFSS_SLEEP_RST;
         r.stat   <= `IFSS_STAT_RST;
      end
      else
         r <= n;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign reg_rdata               = r.rdata;
   assign tilt_full_circle_output = r.outs[0];
   assign tilt_signed_half_output = r.outs[1];
   assign supply_output           = r.outs[2];
   assign aux_adc_output          = r.outs[3];
   assign temp_output             = r.outs[4];
   assign new_data_pin            = r.nd_pin;
   assign dac_power_down          = r.dac_pd;
   assign cmd_soft_reset          = r.cmd[`IFSS_CMD_SOFT_RST];
   assign cmd_flash_store         = r.cmd[`IFSS_CMD_FLASH];
   assign cmd_dac_latch           = r.cmd[`IFSS_CMD_DAC_LATCH];
   assign cmd_factory_reset       = r.cmd[`IFSS_CMD_FACTORY];
   assign cmd_incl_null           = r.cmd[`IFSS_CMD_NULL];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [31:0] rec_cnt;

   // Length of the current recovery stretch
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         rec_cnt <= 32'h0000_0000;
      else if (r.st == ifss_pkg::ifss_st_recover)
         rec_cnt <= rec_cnt + 32'h0000_0001;
      else
         rec_cnt <= 32'h0000_0000;
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_last_update;
      r.st == ifss_pkg::ifss_st_run && upd && r.slp != 8'h00;
   endsequence

   sequence s_wake;
      r.st == ifss_pkg::ifss_st_sleep ##1 r.st == ifss_pkg::ifss_st_recover;
   endsequence

   sequence s_clr_write;
      reg_wr_en && reg_addr == `IFSS_ADDR_CMD_LO && reg_wdata[`IFSS_CMD_CLEAR];
   endsequence

   sequence s_null_write;
      reg_wr_en && reg_addr == `IFSS_ADDR_CMD_LO && reg_wdata[`IFSS_CMD_NULL];
   endsequence

   property p_sleep_entry;
      s_last_update |=> r.st == ifss_pkg::ifss_st_sleep && !r.nd_pin && !r.outs[0][`IFSS_OUT_ND] && r.dac_pd;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

   property p_wake_clear;
      s_wake |-> r.slp == 8'h00 && !r.dac_pd;
   endproperty
   a_wake_clear: assert property (p_wake_clear) else $error("sleep count not cleared on wake");

   property p_recover_len;
      $fell(r.st == ifss_pkg::ifss_st_recover) |-> $past(rec_cnt) == 32'(RECOVER_CYC - 1);
   endproperty
   a_recover_len: assert property (p_recover_len) else $error("recovery length wrong");

   property p_sticky;
      cond_alarm1 |=> r.stat[`IFSS_ST_ALARM1];
   endproperty
   a_sticky: assert property (p_sticky) else $error("alarm flag not set");

   property p_clear;
      s_clr_write ##1 cond_vec == 10'h000 |=> r.stat == 10'h000;
   endproperty
   a_clear: assert property (p_clear) else $error("status clear failed");

   property p_supply;
      $past(rst_b) |-> r.stat[1:0] == $past(cond_vec[1:0]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply flag wrong");

   property p_depth_max;
      r.fdepth <= `IFSS_FDEPTH_MAX;
   endproperty
   a_depth_max: assert property (p_depth_max) else $error("depth above limit");

   property p_cmd_once;
      s_null_write ##1 !reg_wr_en |-> r.cmd[`IFSS_CMD_NULL] ##1 !r.cmd[`IFSS_CMD_NULL];
   endproperty
   a_cmd_once: assert property (p_cmd_once) else $error("command not one pulse");

   property p_alarm_bit;
      r.st == ifss_pkg::ifss_st_run && upd |=> r.outs[0][`IFSS_OUT_ALARM] == |$past(r.stat);
   endproperty
   a_alarm_bit: assert property (p_alarm_bit) else $error("alarm bit wrong");

endmodule

//--- common/ifss_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IFSS_MAP_SVH
`define IFSS_MAP_SVH

// Byte addresses of the register pairs, low byte first
`define IFSS_ADDR_FDEPTH_LO 7'h38
`define IFSS_ADDR_FDEPTH_HI 7'h39
`define IFSS_ADDR_SLEEP_LO  7'h3A
`define IFSS_ADDR_SLEEP_HI  7'h3B
`define IFSS_ADDR_STAT_LO   7'h3C
`define IFSS_ADDR_STAT_HI   7'h3D
`define IFSS_ADDR_CMD_LO    7'h3E
`define IFSS_ADDR_CMD_HI    7'h3F

// Reset values and limits
`define IFSS_FDEPTH_RST     4'h7
`define IFSS_FDEPTH_MAX     4'h8
`define IFSS_SLEEP_RST      8'h00
`define IFSS_STAT_RST       10'h000
`define IFSS_STAT_STICKY    10'h36C
`define IFSS_CMD_MASK       8'h9F

// Status bit positions
`define IFSS_ST_UNDER       0
`define IFSS_ST_OVER        1
`define IFSS_ST_CTRL_FAIL   2
`define IFSS_ST_SPI_FAIL    3
`define IFSS_ST_SELFTEST    5
`define IFSS_ST_ORIENT      6
`define IFSS_ST_ALARM1      8
`define IFSS_ST_ALARM2      9

// Command bit positions
`define IFSS_CMD_NULL       0
`define IFSS_CMD_FACTORY    1
`define IFSS_CMD_DAC_LATCH  2
`define IFSS_CMD_FLASH      3
`define IFSS_CMD_CLEAR      4
`define IFSS_CMD_SOFT_RST   7

// Output data word fields
`define IFSS_OUT_ND         15
`define IFSS_OUT_ALARM      14

// Timing: clock rate, sleep unit and converter recovery
`define IFSS_MCLK_HZ        50000000
`define IFSS_SLEEP_UNIT_MS  500
`define IFSS_RECOVER_MS     2
`define IFSS_SLEEP_UNIT_CYC (`IFSS_SLEEP_UNIT_MS * (`IFSS_MCLK_HZ / 1000))
`define IFSS_RECOVER_CYC    (`IFSS_RECOVER_MS * (`IFSS_MCLK_HZ / 1000))

`endif

//--- common/ifss_pkg.sv
// Types shared by the filter, sleep and status block
package ifss_pkg;

   // Power state, Gray coded along run, sleep, recover
   typedef enum logic [1:0]
   {
      ifss_st_run     = 2'b00,
      ifss_st_sleep   = 2'b01,
      ifss_st_recover = 2'b11
   } ifss_state_t;

   // Whole state of the top module
   typedef struct packed
   {
      ifss_state_t      st;
      logic [3:0]       fdepth;
      logic [7:0]       slp;
      logic [7:0]       halves;
      logic [9:0]       stat;
      logic [7:0]       cmd;
      logic [7:0]       rdata;
      logic             nd_pin;
      logic             dac_pd;
      logic [4:0][15:0] outs;
   } ifss_top_state_t;

endpackage

//--- hw/ifss_down_timer.sv
// Loadable down counter that pulses when its count runs out
module ifss_down_timer
#(
   parameter int CW = 32
)
(
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  wire logic          start,
   input  wire logic [CW-1:0] length,
   output logic               done
);

   typedef struct packed
   {
      logic [CW-1:0] cnt;
   } ifss_timer_state_t;

   ifss_timer_state_t r;
   ifss_timer_state_t n;

   // Load on start, otherwise count toward zero
   always_comb
   begin
      n = r;
      if (start)
         n.cnt = length;
      else if (r.cnt != '0)
         n.cnt = r.cnt - CW'(1);
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         r <= '0;
      else
         r <= n;
   end

   // Last cycle of the loaded length
   assign done = (r.cnt == CW'(1));

endmodule

//--- hw/ifss_mavg.sv
// Moving average over 2**depth_exp samples, run on each valid input
module ifss_mavg
#(
   parameter int W    = 14,
   parameter int LMAX = 8
)
(
   input  wire logic                mclk,
   input  wire logic                rst_b,
   input  wire logic                clear,
   input  wire logic                in_valid,
   input  wire logic [3:0]          depth_exp,
   input  wire logic signed [W-1:0] in_data,
   output logic                     out_valid,
   output logic signed [W-1:0]      out_data
);

   localparam int N  = 1 << LMAX;
   localparam int SW = W + LMAX;

   typedef struct packed
   {
      logic [N-1:0][W-1:0] hist;
      logic [LMAX-1:0]     wp;
      logic [SW-1:0]       sum;
      logic [W-1:0]        avg;
      logic                vld;
   } ifss_mavg_state_t;

   ifss_mavg_state_t r;
   ifss_mavg_state_t n;

   // Running sum: add newest, drop the one that leaves the window
   always_comb
   begin
      logic [LMAX:0]        span;
      logic [W-1:0]         oldest;
      logic signed [SW-1:0] sum_new;
      n       = r;
      n.vld   = 1'b0;
      span    = (LMAX+1)'(1) << depth_exp;
      oldest  = r.hist[r.wp - span[LMAX-1:0]];
      sum_new = $signed(r.sum) + $signed({{LMAX{in_data[W-1]}}, in_data})
                - $signed({{LMAX{oldest[W-1]}}, oldest});
      if (clear)
      begin
         n.hist = '0;
         n.sum  = '0;
         n.wp   = '0;
      end
      else if (in_valid)
      begin
         n.hist[r.wp] = in_data;
         n.wp         = r.wp + LMAX'(1);
         n.sum        = sum_new;
         n.avg        = W'(sum_new >>> depth_exp);
         n.vld        = 1'b1;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         r <= '0;
      else
         r <= n;
   end

   assign out_valid = r.vld;
   assign out_data  = r.avg;

endmodule

//--- dv/ifss_host_model.sv
// Host model that drives the byte-wide register port
module ifss_host_model
(
   input  wire logic       mclk,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic [6:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle bus from time zero
   initial
   begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr  = 7'h00;
      reg_wdata = 8'h00;
   end

   // Byte write; released lines show the inverse of the last value
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
      @(posedge mclk);
      #1;
      {reg_wr_en, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
   endtask

   // Byte read; registered data stands only in the cycle after the strobe edge
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge mclk);
      #1;
      {reg_rd_en, reg_addr} = {1'b1, a};
      @(posedge mclk);
      #1;
      {reg_rd_en, reg_addr} = {1'b0, ~a};
      d = reg_rdata;
   endtask
endmodule

//--- dv/ifss_ctrl_bench.sv
// Self-checking bench of the filter, sleep and status block
module ifss_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int SLP     = 20;
   localparam int REC     = 10;
   localparam int SBIT[6] = '{9, 8, 6, 5, 3, 2};

   logic             mclk;
   logic             rst_b;
   logic             reg_wr_en;
   logic             reg_rd_en;
   logic [6:0]       reg_addr;
   logic [7:0]       reg_wdata;
   logic [7:0]       reg_rdata;
   logic             sample_valid;
   logic [4:0][13:0] raw;
   logic [5:0]       conds;
   logic [1:0]       supply;
   logic [4:0][15:0] outs;
   logic             new_data_pin;
   logic             dac_power_down;
   logic [4:0]       pulses;
   logic [15:0]      lfsr;
   logic [7:0]       b;
   logic [15:0]      s;
   int               n_fail;
   int               num_checks;
   int               cyc = 0;
   int               t0;
   int               dep;
   int               ev[5];
   int               q1[5][$];
   int               q2[5][$];

   ////////////////////////////////////////////////////////////
   // Clock and free cycle count
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;

   // Design and host
   ifss_ctrl #(.SLEEP_UNIT_CYC (SLP), .RECOVER_CYC (REC), .DW (14)) i_ifss_ctrl
   (
      .mclk (mclk), .rst_b (rst_b), .reg_wr_en (reg_wr_en), .reg_rd_en (reg_rd_en),
      .reg_addr (reg_addr), .reg_wdata (reg_wdata), .reg_rdata (reg_rdata), .sample_valid (sample_valid),
      .raw_tilt_full (raw[0]), .raw_tilt_half (raw[1]), .raw_supply (raw[2]), .raw_aux_adc (raw[3]),
      .raw_temp (raw[4]), .cond_alarm2 (conds[0]), .cond_alarm1 (conds[1]), .cond_orient (conds[2]),
      .cond_selftest_fail (conds[3]), .cond_spi_fail (conds[4]), .cond_ctrl_fail (conds[5]),
      .supply_over (supply[1]), .supply_under (supply[0]), .tilt_full_circle_output (outs[0]),
      .tilt_signed_half_output (outs[1]), .supply_output (outs[2]), .aux_adc_output (outs[3]),
      .temp_output (outs[4]), .new_data_pin (new_data_pin), .dac_power_down (dac_power_down),
      .cmd_soft_reset (pulses[4]), .cmd_flash_store (pulses[3]), .cmd_dac_latch (pulses[2]),
      .cmd_factory_reset (pulses[1]), .cmd_incl_null (pulses[0])
   );
   ifss_host_model i_ifss_host_model
   (
      .mclk (mclk), .reg_rdata (reg_rdata), .reg_wr_en (reg_wr_en), .reg_rd_en (reg_rd_en),
      .reg_addr (reg_addr), .reg_wdata (reg_wdata)
   );

   ////////////////////////////////////////////////////////////
   // Reference functions and shared tasks
   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic int avg(input int q[$], input int n);
      int t;
      t = 0;
      foreach (q[i]) t += q[i];
      return t / n;
   endfunction

   function automatic logic [4:0] cmd_exp(input int k);
      return {k == 7, k == 3, k == 2, k == 1, k == 0};
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Restart the reference windows, empty history reads as zeros
   task automatic model_clear(input int d);
      dep = d;
      foreach (q1[c])
      begin
         q1[c].delete();
         q2[c].delete();
      end
   endtask

   // Tilt channels average twice, the others once
   task automatic push(input int c, input int v);
      q1[c].push_front(v);
      if (q1[c].size() > (1 << dep))
         void'(q1[c].pop_back());
      q2[c].push_front(avg(q1[c], 1 << dep));
      if (q2[c].size() > (1 << dep))
         void'(q2[c].pop_back());
      ev[c] = (c < 2) ? avg(q2[c], 1 << dep) : q2[c][0];
   endtask

   // One sample period, then all outputs compared two cycles on
   task automatic do_sample(input bit acc, input bit nd, input bit al);
      @(posedge mclk);
      #1;
      sample_valid = 1'b1;
      for (int c = 0; c < 5; c++)
      begin
         lfsr = lfsr_next(lfsr);
         raw[c] = {1'b0, lfsr[12:0]};
         if (acc)
            push(c, int'(lfsr[12:0]));
      end
      @(posedge mclk);
      #1;
      sample_valid = 1'b0;
      raw = ~raw;
      repeat (2) @(posedge mclk);
      #1;
      for (int c = 0; c < 5; c++)
         check(outs[c], {nd, al, 14'(ev[c])});
      check(16'(new_data_pin), 16'(nd));
   endtask

   task automatic rd_stat(output logic [15:0] v);
      i_ifss_host_model.rd(7'h3D, v[15:8]);
      i_ifss_host_model.rd(7'h3C, v[7:0]);
   endtask

   ////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {rst_b, sample_valid, raw, conds, supply} = '0;
      n_fail = 0;
      num_checks = 0;
      lfsr = 16'h1D2F;
      ev = '{0, 0, 0, 0, 0};
      model_clear(7);
      repeat (5) @(posedge mclk);
      #1;
      rst_b = 1'b1;
      for (int i = 0; i < 9; i++)
      begin
         i_ifss_host_model.rd((i == 8) ? 7'h10 : 7'(8'h38 + i), b);
         check(16'(b), (i == 0) ? 16'h0007 : 16'h0000);
      end
      $display("Test reset values done");
      for (int d = 0; d <= 8; d++)
      begin
         i_ifss_host_model.wr(7'h38, 8'(d));
         i_ifss_host_model.rd(7'h38, b);
         check(16'(b), 16'(d));
         model_clear(d);
         repeat ((2 << d) + 2) do_sample(1'b1, 1'b1, 1'b0);
      end
      i_ifss_host_model.wr(7'h38, 8'h09);
      i_ifss_host_model.wr(7'h39, 8'hFF);
      i_ifss_host_model.rd(7'h38, b);
      check(16'(b), 16'h0008);
      i_ifss_host_model.rd(7'h39, b);
      check(16'(b), 16'h0000);
      i_ifss_host_model.wr(7'h38, 8'hA3);
      i_ifss_host_model.rd(7'h38, b);
      check(16'(b), 16'h0003);
      model_clear(3);
      $display("Test filter depths done");
      for (int i = 0; i < 6; i++)
      begin
         @(posedge mclk);
         #1;
         conds = 6'(1 << i);
         @(posedge mclk);
         #1;
         conds = 6'h00;
         rd_stat(s);
         check(s, 16'(1 << SBIT[i]));
         do_sample(1'b1, 1'b1, 1'b1);
         i_ifss_host_model.wr(7'h3E, 8'h10);
         repeat (2) @(posedge mclk);
         rd_stat(s);
         check(s, 16'h0000);
      end
      conds = 6'h01;
      i_ifss_host_model.wr(7'h3E, 8'h10);
      repeat (2) @(posedge mclk);
      rd_stat(s);
      check(s, 16'h0200);
      conds = 6'h00;
      i_ifss_host_model.wr(7'h3E, 8'h10);
      for (int j = 0; j < 2; j++)
      begin
         supply = 2'(2 >> j);
         rd_stat(s);
         check(s, 16'(2 >> j));
         supply = 2'b00;
         rd_stat(s);
         check(s, 16'h0000);
      end
      $display("Test status flags done");
      for (int k = 0; k < 8; k++)
      begin
         i_ifss_host_model.wr(7'h3E, 8'(1 << k));
         check(16'(pulses), 16'(cmd_exp(k)));
         @(posedge mclk);
         #1;
         check(16'(pulses), 16'h0000);
      end
      i_ifss_host_model.wr(7'h3F, 8'hFF);
      check(16'(pulses), 16'h0000);
      model_clear(3);
      $display("Test commands done");
      i_ifss_host_model.wr(7'h3A, 8'h02);
      i_ifss_host_model.rd(7'h3A, b);
      check(16'(b), 16'h0002);
      do_sample(1'b1, 1'b0, 1'b0);
      t0 = cyc;
      check(16'(dac_power_down), 16'h0001);
      do_sample(1'b0, 1'b0, 1'b0);
      i_ifss_host_model.rd(7'h38, b);
      check(16'(b), 16'h0003);
      while (dac_power_down === 1'b1 && cyc - t0 < 200)
      begin
         @(posedge mclk);
         #1;
      end
      check(16'(cyc - t0 >= 2 * SLP - 1 && cyc - t0 <= 2 * SLP + 1), 16'h0001);
      i_ifss_host_model.rd(7'h3A, b);
      check(16'(b), 16'h0000);
      do_sample(1'b0, 1'b0, 1'b0);
      repeat (REC) @(posedge mclk);
      do_sample(1'b1, 1'b1, 1'b0);
      i_ifss_host_model.wr(7'h3A, 8'h03);
      do_sample(1'b1, 1'b0, 1'b0);
      repeat (10) @(posedge mclk);
      #1;
      rst_b = 1'b0;
      @(posedge mclk);
      #1;
      check({dac_power_down, outs[0][14:0]}, 16'h0000);
      rst_b = 1'b1;
      i_ifss_host_model.rd(7'h3A, b);
      check(16'(b), 16'h0000);
      ev = '{0, 0, 0, 0, 0};
      model_clear(7);
      do_sample(1'b1, 1'b1, 1'b0);
      $display("Test power-down done");
      finish_test();
   end

   // Watchdog against a hung handshake
   initial
   begin
      #(20 * 40000);
      n_fail++;
      finish_test();
   end
endmodule
